/* core/atr_ctrl.sv */
// attenuator control and converter overload reset logic
//
// Overview of operation
// - mode zero: gain pin two picks preset
// - mode one: pins decrement and increment attenuation
// - pin two low applies low preset, reset 12
// - pin two high applies high preset, reset 12
// - codes 0..27 attenuate; 28..31 disable attenuator
// - stepping mode starts from the start register
// - readback bit 7 shows pin two level
// - readback low bits show effective attenuation
// - overload when full-scale count exceeds threshold
// - reset pulse lasts (length+1) times eight clocks
// - each overload outside a reset pulse at codes 0..27 raises attenuation by step
// - overload-raised attenuation saturates at 27
// - overload sets sticky unstable flag, write clear
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ns
`include "atr_cfg.svh"

module atr_ctrl (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // register port
    input  wire atr_pkg::atr_bus_req_t  bus_req,
    output logic [7:0]                  bus_rdata,
    // gain control pins
    input  wire logic                   gain_pin_one,
    input  wire logic                   gain_pin_two,
    // converter samples
    input  wire logic                   sample_valid,
    input  wire logic signed [4:0]      sample_data,
    // converter side outputs
    output atr_pkg::atr_atten_t         atten_out,
    output logic                        adc_reset_out,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;
    logic [1:0] pin_last_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
            pin_last_reg <= 2'h0;
        end else begin
            pin_meta_reg <= {gain_pin_two, gain_pin_one};
            pin_sync_reg <= pin_meta_reg;
            pin_last_reg <= pin_sync_reg;
        end
    end

    logic pin_two_level;
    logic dec_cmd;
    logic inc_cmd;
    assign pin_two_level = pin_sync_reg[1];
    assign dec_cmd = pin_sync_reg[0] & ~pin_last_reg[0];
    assign inc_cmd = pin_sync_reg[1] & ~pin_last_reg[1];

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    logic       mode_reg;
    logic [7:0] pre_lo_reg;
    logic [7:0] pre_hi_reg;
    logic [7:0] start_reg;
    logic [2:0] thresh_reg;
    logic [4:0] pulse_len_reg;
    logic [4:0] step_reg;
    logic [1:0] irq_mask_reg;
    logic       wr_start;

    assign wr_start = bus_req.wr && bus_req.addr == `ATR_OFF_START;

    always_ff @(posedge clk) begin
        if (rst) begin
            mode_reg      <= 1'(`ATR_RST_MODE);
            pre_lo_reg    <= `ATR_RST_PRESET;
            pre_hi_reg    <= `ATR_RST_PRESET;
            start_reg     <= `ATR_RST_START;
            thresh_reg    <= `ATR_RST_THRESH;
            pulse_len_reg <= `ATR_RST_PULSE;
            step_reg      <= `ATR_RST_STEP;
            irq_mask_reg  <= 2'h0;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `ATR_OFF_MODE:     mode_reg      <= bus_req.wdata[0];
                `ATR_OFF_PRE_LO:   pre_lo_reg    <= bus_req.wdata;
                `ATR_OFF_PRE_HI:   pre_hi_reg    <= bus_req.wdata;
                `ATR_OFF_START:    start_reg     <= bus_req.wdata;
                `ATR_OFF_THRESH:   thresh_reg    <= bus_req.wdata[2:0];
                `ATR_OFF_PULSE:    pulse_len_reg <= bus_req.wdata[4:0];
                `ATR_OFF_STEP:     step_reg      <= bus_req.wdata[4:0];
                `ATR_OFF_IRQ_MASK: irq_mask_reg  <= bus_req.wdata[1:0];
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // full-scale counting over groups of eight samples
    logic       is_fs;
    logic [2:0] grp_idx_reg;
    logic [3:0] fs_cnt_reg;
    logic [3:0] fs_total;
    logic       grp_end;
    logic       ov_trig;
    atr_pkg::atr_ov_state_t ov_state_reg;

    assign is_fs = sample_data == `ATR_FS_POS || sample_data == `ATR_FS_NEG;
    assign fs_total = fs_cnt_reg + {3'h0, is_fs};
    assign grp_end = sample_valid && grp_idx_reg == `ATR_GROUP_LAST;
    assign ov_trig = grp_end && fs_total > {1'b0, thresh_reg}
        && ov_state_reg == atr_pkg::ATR_OV_IDLE;

    always_ff @(posedge clk) begin
        if (rst) begin
            grp_idx_reg <= 3'h0;
            fs_cnt_reg  <= 4'h0;
        end else if (sample_valid) begin
            grp_idx_reg <= grp_idx_reg + 3'h1;
            fs_cnt_reg  <= grp_end ? 4'h0 : fs_total;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter reset pulse
    logic [8:0] pulse_cnt_reg;
    logic [8:0] pulse_load;

    assign pulse_load = {4'h0, pulse_len_reg} + 9'h001;

    always_ff @(posedge clk) begin
        if (rst) begin
            ov_state_reg  <= atr_pkg::ATR_OV_IDLE;
            pulse_cnt_reg <= 9'h000;
        end else begin
            case (ov_state_reg)
                atr_pkg::ATR_OV_IDLE: begin
                    if (ov_trig) begin
                        ov_state_reg  <= atr_pkg::ATR_OV_PULSE;
                        pulse_cnt_reg <= 9'(pulse_load << `ATR_PULSE_SHIFT);
                    end
                end
                atr_pkg::ATR_OV_PULSE: begin
                    pulse_cnt_reg <= pulse_cnt_reg - 9'h001;
                    if (pulse_cnt_reg == 9'h001) begin
                        ov_state_reg <= atr_pkg::ATR_OV_IDLE;
                    end
                end
                default: begin
                    ov_state_reg  <= atr_pkg::ATR_OV_IDLE;
                    pulse_cnt_reg <= 9'h000;
                end
            endcase
        end
    end

    assign adc_reset_out = ov_state_reg == atr_pkg::ATR_OV_PULSE;

    ////////////////////////////////////////////////////////////////////////
    // attenuation value
    logic [4:0] preset_sel;
    logic [4:0] last_sel_reg;
    logic       last_mode_reg;
    logic [4:0] atten_reg;
    logic [4:0] atten_next;
    logic [4:0] start_clip;
    logic [7:0] start_src;
    logic [5:0] stepped;

    assign preset_sel = pin_two_level ? pre_hi_reg[4:0]
                                      : pre_lo_reg[4:0];
    // a start write in stepping mode loads the value being written now
    assign start_src = wr_start ? bus_req.wdata : start_reg;
    assign start_clip = start_src > {3'h0, `ATR_ATTEN_MAX}
                        ? `ATR_ATTEN_MAX : start_src[4:0];
    assign stepped = {1'b0, atten_reg} + {1'b0, step_reg};

    always_comb begin
        atten_next = atten_reg;
        if (ov_trig && atten_reg <= `ATR_ATTEN_MAX) begin
            atten_next = stepped > {1'b0, `ATR_ATTEN_MAX}
                         ? `ATR_ATTEN_MAX : stepped[4:0];
        end else if (!mode_reg) begin
            if (preset_sel != last_sel_reg || last_mode_reg) begin
                atten_next = preset_sel;
            end
        end else if (!last_mode_reg || wr_start) begin
            atten_next = start_clip;
        end else if (dec_cmd && !inc_cmd) begin
            if (atten_reg != `ATR_ATTEN_MIN) begin
                atten_next = atten_reg - 5'h01;
            end
        end else if (inc_cmd && !dec_cmd) begin
            if (atten_reg < `ATR_ATTEN_MAX) begin
                atten_next = atten_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            atten_reg     <= `ATR_RST_ATTEN;
            last_sel_reg  <= `ATR_RST_ATTEN;
            last_mode_reg <= 1'b0;
        end else begin
            atten_reg     <= atten_next;
            last_sel_reg  <= preset_sel;
            last_mode_reg <= mode_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            atten_out <= '{code: `ATR_RST_ATTEN, disable_att: 1'b0};
        end else begin
            atten_out.code        <= atten_next;
            atten_out.disable_att <= atten_next > `ATR_ATTEN_MAX;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // unstable flag and interrupts
    logic       unstable_reg;
    logic [1:0] irq_stat_reg;
    logic [1:0] irq_evt;
    logic       clr_unstable;

    assign clr_unstable = bus_req.wr && bus_req.addr == `ATR_OFF_UNSTABLE
                          && bus_req.wdata[`ATR_BIT_CLEAR_UNST];
    assign irq_evt = {atten_next != atten_reg, ov_trig};

    always_ff @(posedge clk) begin
        if (rst) begin
            unstable_reg <= 1'b0;
        end else if (ov_trig) begin
            unstable_reg <= 1'b1;
        end else if (clr_unstable) begin
            unstable_reg <= 1'b0;
        end
    end

    generate
        for (genvar i = 0; i < 2; i++) begin : g_irq
            always_ff @(posedge clk) begin
                if (rst) begin
                    irq_stat_reg[i] <= 1'b0;
                end else if (irq_evt[i]) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (bus_req.wr && bus_req.wdata[i]
                             && bus_req.addr == `ATR_OFF_IRQ_STAT) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    assign irq = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // register read port
    logic [7:0] rdata_next;

    always_comb begin
        rdata_next = 8'h00;
        case (bus_req.addr)
            `ATR_OFF_MODE:     rdata_next = {7'h00, mode_reg};
            `ATR_OFF_PRE_LO:   rdata_next = pre_lo_reg;
            `ATR_OFF_PRE_HI:   rdata_next = pre_hi_reg;
            `ATR_OFF_START:    rdata_next = start_reg;
            `ATR_OFF_READBACK: rdata_next = {pin_two_level,
                                             2'h0, atten_reg};
            `ATR_OFF_THRESH:   rdata_next = {5'h00, thresh_reg};
            `ATR_OFF_PULSE:    rdata_next = {3'h0, pulse_len_reg};
            `ATR_OFF_STEP:     rdata_next = {3'h0, step_reg};
            `ATR_OFF_IRQ_STAT: rdata_next = {6'h00, irq_stat_reg};
            `ATR_OFF_IRQ_MASK: rdata_next = {6'h00, irq_mask_reg};
            `ATR_OFF_UNSTABLE: rdata_next = {7'h00, unstable_reg};
            default:           rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bus_rdata <= 8'h00;
        end else begin
            bus_rdata <= bus_req.rd ? rdata_next : 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic [8:0] chk_hi_cnt;
    logic [8:0] chk_len_reg;

    always_ff @(posedge clk) begin
        if (rst) begin
            chk_hi_cnt  <= 9'h000;
            chk_len_reg <= 9'h000;
        end else begin
            chk_hi_cnt <= adc_reset_out ? chk_hi_cnt + 9'h001 : 9'h000;
            if (ov_trig) begin
                chk_len_reg <= {({1'b0, pulse_len_reg} + 6'h01), 3'h0};
            end
        end
    end

    chk_preset_apply: assert property (@(posedge clk) disable iff (rst)
        !mode_reg && !last_mode_reg && !ov_trig
        && preset_sel != last_sel_reg |=> atten_reg == $past(preset_sel))
        else $error("preset not applied");

    chk_preset_low: assert property (@(posedge clk) disable iff (rst)
        !mode_reg && !last_mode_reg && !ov_trig && !pin_two_level
        && preset_sel != last_sel_reg |=> atten_reg == $past(pre_lo_reg[4:0]))
        else $error("low preset not applied");

    chk_preset_high: assert property (@(posedge clk) disable iff (rst)
        !mode_reg && !last_mode_reg && !ov_trig && pin_two_level
        && preset_sel != last_sel_reg |=> atten_reg == $past(pre_hi_reg[4:0]))
        else $error("high preset not applied");

    chk_disable_code: assert property (@(posedge clk) disable iff (rst)
        ##1 atten_out.disable_att == (atten_reg > `ATR_ATTEN_MAX))
        else $error("disable flag wrong");

    chk_start_load: assert property (@(posedge clk) disable iff (rst)
        mode_reg && !last_mode_reg && !ov_trig |=> atten_reg == $past(start_clip))
        else $error("start value not loaded");

    chk_step_down: assert property (@(posedge clk) disable iff (rst)
        mode_reg && last_mode_reg && !wr_start && !ov_trig && dec_cmd
        && !inc_cmd && atten_reg != 5'h00 |=> atten_reg == $past(atten_reg) - 5'h01)
        else $error("decrement missing");

    chk_step_floor: assert property (@(posedge clk) disable iff (rst)
        mode_reg && last_mode_reg && !ov_trig && !wr_start
        && atten_reg == 5'h00 && dec_cmd |=> atten_reg == 5'h00)
        else $error("decrement wrapped");

    chk_pin_readback: assert property (@(posedge clk) disable iff (rst)
        bus_req.rd && bus_req.addr == `ATR_OFF_READBACK
        |=> bus_rdata[7] == $past(pin_two_level)
            && bus_rdata[4:0] == $past(atten_reg))
        else $error("readback wrong");

    chk_below_thresh: assert property (@(posedge clk) disable iff (rst)
        grp_end && fs_total <= {1'b0, thresh_reg} |-> !ov_trig)
        else $error("overload below threshold");

    chk_pulse_len: assert property (@(posedge clk) disable iff (rst)
        $fell(adc_reset_out) |-> chk_hi_cnt == chk_len_reg)
        else $error("pulse length wrong");

    chk_min_pulse: assert property (@(posedge clk) disable iff (rst)
        ov_trig |=> adc_reset_out [*8])
        else $error("pulse too short");

    chk_step_raise: assert property (@(posedge clk) disable iff (rst)
        ov_trig && stepped <= 6'h1B |=> atten_reg == $past(stepped[4:0]))
        else $error("overload step wrong");

    chk_step_clip: assert property (@(posedge clk) disable iff (rst)
        ov_trig && stepped > 6'h1B && atten_reg <= 5'h1B |=> atten_reg == 5'h1B)
        else $error("overload not clipped");

    chk_unstable_set: assert property (@(posedge clk) disable iff (rst)
        ov_trig |=> unstable_reg ##1 (unstable_reg || $past(clr_unstable)))
        else $error("unstable flag not sticky");

    chk_no_retrig: assert property (@(posedge clk) disable iff (rst)
        adc_reset_out |-> !ov_trig)
        else $error("retrigger during pulse");

    cov_overload: cover property (@(posedge clk) disable iff (rst)
        ov_trig ##1 adc_reset_out);
    cov_clip: cover property (@(posedge clk) disable iff (rst)
        ov_trig && stepped > 6'h1B);
    cov_step_up: cover property (@(posedge clk) disable iff (rst)
        mode_reg && last_mode_reg && inc_cmd ##1 irq);
    cov_preset_swap: cover property (@(posedge clk) disable iff (rst)
        !mode_reg && $rose(pin_two_level));

endmodule : atr_ctrl

/* shared/atr_cfg.svh */
// constants for the attenuator and overload reset controller
`ifndef ATR_CFG_SVH
`define ATR_CFG_SVH
`define ATR_AW             10
`define ATR_OFF_MODE       10'h180
`define ATR_OFF_PRE_LO     10'h181
`define ATR_OFF_PRE_HI     10'h182
`define ATR_OFF_START      10'h183
`define ATR_OFF_READBACK   10'h184
`define ATR_OFF_THRESH     10'h188
`define ATR_OFF_PULSE      10'h189
`define ATR_OFF_STEP       10'h18A
`define ATR_OFF_IRQ_STAT   10'h18C
`define ATR_OFF_IRQ_MASK   10'h18D
`define ATR_OFF_UNSTABLE   10'h18F
`define ATR_RST_MODE       8'h00
`define ATR_RST_PRESET     8'h0C
`define ATR_RST_START      8'h00
`define ATR_RST_ATTEN      5'h0C
`define ATR_RST_THRESH     3'h5
`define ATR_RST_PULSE      5'h01
`define ATR_RST_STEP       5'h06
`define ATR_ATTEN_MAX      5'h1B
`define ATR_ATTEN_MIN      5'h00
`define ATR_FS_POS         5'sh08
`define ATR_FS_NEG         -5'sh08
`define ATR_GROUP_LAST     3'h7
`define ATR_PULSE_SHIFT    3
`define ATR_BIT_PIN_LEVEL  7
`define ATR_BIT_CLEAR_UNST 1
`define ATR_IRQ_OVERLOAD   0
`define ATR_IRQ_ATTEN_CHG  1
`endif

/* shared/atr_pkg.sv */
// types for the attenuator and overload reset controller
package atr_pkg;
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } atr_bus_req_t;

    typedef struct packed {
        logic [4:0] code;
        logic       disable_att;
    } atr_atten_t;

    typedef enum logic [1:0] {
        ATR_OV_IDLE  = 2'b01,
        ATR_OV_PULSE = 2'b10
    } atr_ov_state_t;
endpackage : atr_pkg

/* testbench/atr_host_agc.sv */
// host gain-control model that drives the two gain pins
`timescale 1ns/1ns

module atr_host_agc #(
    parameter int HOLD = 2
) (
    // clock
    input  wire logic clk,
    // gain pins
    output logic      gain_pin_one,
    output logic      gain_pin_two
);
    int hold_cycles = HOLD;

    initial begin
        gain_pin_one = 1'b0;
        gain_pin_two = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // every level is held at least two clocks so the synchroniser sees it
    task automatic pulse_pin(logic which);
        @(posedge clk);
        if (which) begin
            gain_pin_two <= 1'b1;
        end else begin
            gain_pin_one <= 1'b1;
        end
        repeat (hold_cycles) @(posedge clk);
        gain_pin_one <= 1'b0;
        gain_pin_two <= 1'b0;
        repeat (hold_cycles) @(posedge clk);
    endtask : pulse_pin

    task automatic step_down;
        pulse_pin(1'b0);
    endtask : step_down

    task automatic step_up;
        pulse_pin(1'b1);
    endtask : step_up

    task automatic select(logic level);
        @(posedge clk);
        gain_pin_two <= level;
        repeat (hold_cycles) @(posedge clk);
    endtask : select
endmodule : atr_host_agc

/* testbench/tb_top.sv */
// testbench for the attenuator and overload reset controller
`timescale 1ns/1ns
`include "atr_cfg.svh"

module tb_top;
    logic                  clk;
    logic                  rst;
    atr_pkg::atr_bus_req_t bus_req;
    logic [7:0]            bus_rdata;
    logic                  gain_pin_one;
    logic                  gain_pin_two;
    logic                  sample_valid;
    logic signed [4:0]     sample_data;
    atr_pkg::atr_atten_t   atten_out;
    logic                  adc_reset_out;
    logic                  irq;
    int                    err_count;
    int                    checked;
    int                    hi_cnt;

    atr_ctrl u_dut (.clk(clk), .rst(rst), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .gain_pin_one(gain_pin_one),
        .gain_pin_two(gain_pin_two), .sample_valid(sample_valid),
        .sample_data(sample_data), .atten_out(atten_out),
        .adc_reset_out(adc_reset_out), .irq(irq));

    atr_host_agc #(.HOLD(3)) u_host (.clk(clk),
        .gain_pin_one(gain_pin_one), .gain_pin_two(gain_pin_two));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // counts the edges that see the converter reset pulse high
    always @(posedge clk) begin
        if (adc_reset_out === 1'b1) hi_cnt++;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk_val(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_val

    task automatic chk_bit(string what, logic exp, logic got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic wait_clk(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task automatic reg_wr(logic [9:0] a, logic [7:0] d);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(string what, logic [9:0] a, logic [7:0] exp);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
        #1;
        chk_val(what, exp, bus_rdata);
    endtask : rd_chk

    task automatic code_chk(string what, logic [7:0] exp);
        chk_val(what, exp, {3'h0, atten_out.code});
    endtask : code_chk

    // eight samples, the first nfs of them alternately +8 and -8
    task automatic send_group(int nfs);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            sample_valid <= 1'b1;
            sample_data  <= (i < nfs) ? (i[0] ? 5'h18 : 5'h08) : 5'h03;
        end
        @(posedge clk);
        sample_valid <= 1'b0;
        #1;
    endtask : send_group

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        rd_chk("mode", `ATR_OFF_MODE, 8'h00);
        rd_chk("preset low", `ATR_OFF_PRE_LO, 8'h0C);
        rd_chk("preset high", `ATR_OFF_PRE_HI, 8'h0C);
        rd_chk("start", `ATR_OFF_START, 8'h00);
        rd_chk("readback", `ATR_OFF_READBACK, 8'h0C);
        rd_chk("threshold", `ATR_OFF_THRESH, 8'h05);
        rd_chk("pulse length", `ATR_OFF_PULSE, 8'h01);
        rd_chk("step", `ATR_OFF_STEP, 8'h06);
        rd_chk("unstable", `ATR_OFF_UNSTABLE, 8'h00);
        reg_wr(10'h185, 8'hFF);
        rd_chk("unmapped", 10'h185, 8'h00);
    endtask : t_reset

    task automatic t_overload;
        reg_wr(`ATR_OFF_IRQ_MASK, 8'h01);
        send_group(5);
        chk_bit("trigger at threshold", 1'b0, adc_reset_out);
        hi_cnt = 0;
        send_group(6);
        chk_bit("trigger above", 1'b1, adc_reset_out);
        code_chk("stepped", 8'h12);
        chk_bit("overload irq", 1'b1, irq);
        wait_clk(30);
        chk_val("pulse cycles", 8'h10, hi_cnt[7:0]);
        rd_chk("unstable set", `ATR_OFF_UNSTABLE, 8'h01);
        reg_wr(`ATR_OFF_IRQ_STAT, 8'h01);
        wait_clk(1);
        chk_bit("irq cleared", 1'b0, irq);
        rd_chk("unstable kept", `ATR_OFF_UNSTABLE, 8'h01);
        reg_wr(`ATR_OFF_UNSTABLE, 8'h02);
        rd_chk("unstable clear", `ATR_OFF_UNSTABLE, 8'h00);
        reg_wr(`ATR_OFF_PULSE, 8'h03);
        rd_chk("pulse written", `ATR_OFF_PULSE, 8'h03);
        hi_cnt = 0;
        send_group(8);
        send_group(8);
        code_chk("one step in pulse", 8'h18);
        wait_clk(40);
        chk_val("long pulse", 8'h20, hi_cnt[7:0]);
        send_group(7);
        code_chk("clipped", 8'h1B);
        wait_clk(40);
    endtask : t_overload

    task automatic t_preset;
        reg_wr(`ATR_OFF_PRE_LO, 8'h03);
        reg_wr(`ATR_OFF_PRE_HI, 8'h1C);
        wait_clk(2);
        code_chk("low preset", 8'h03);
        u_host.select(1'b1);
        wait_clk(4);
        code_chk("high preset", 8'h1C);
        chk_bit("disabled", 1'b1, atten_out.disable_att);
        rd_chk("readback high", `ATR_OFF_READBACK, 8'h9C);
        reg_wr(`ATR_OFF_PRE_HI, 8'h1B);
        wait_clk(2);
        chk_bit("enabled at 27", 1'b0, atten_out.disable_att);
        u_host.select(1'b0);
        wait_clk(4);
        rd_chk("readback low", `ATR_OFF_READBACK, 8'h03);
    endtask : t_preset

    task automatic t_stepping;
        reg_wr(`ATR_OFF_START, 8'h1A);
        reg_wr(`ATR_OFF_IRQ_STAT, 8'h03);
        reg_wr(`ATR_OFF_IRQ_MASK, 8'h00);
        reg_wr(`ATR_OFF_MODE, 8'h01);
        wait_clk(2);
        code_chk("start value", 8'h1A);
        u_host.step_up();
        wait_clk(2);
        code_chk("increment", 8'h1B);
        u_host.hold_cycles = 6;
        u_host.step_up();
        wait_clk(2);
        code_chk("top saturate", 8'h1B);
        chk_bit("masked irq", 1'b0, irq);
        rd_chk("change status", `ATR_OFF_IRQ_STAT, 8'h02);
        reg_wr(`ATR_OFF_IRQ_MASK, 8'h02);
        wait_clk(1);
        chk_bit("unmasked irq", 1'b1, irq);
        reg_wr(`ATR_OFF_IRQ_STAT, 8'h02);
        wait_clk(1);
        chk_bit("irq clear", 1'b0, irq);
        u_host.step_down();
        wait_clk(2);
        code_chk("decrement", 8'h1A);
        reg_wr(`ATR_OFF_START, 8'h00);
        wait_clk(2);
        code_chk("reload", 8'h00);
        u_host.step_down();
        wait_clk(2);
        code_chk("bottom saturate", 8'h00);
    endtask : t_stepping

    ////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        err_count    = 0;
        checked      = 0;
        hi_cnt       = 0;
        rst          = 1'b1;
        bus_req      = '0;
        sample_valid = 1'b0;
        sample_data  = 5'h00;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        wait_clk(2);
        t_reset();
        t_overload();
        t_preset();
        t_stepping();
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("ERROR watchdog expected finish seen timeout");
        tally_and_finish();
    end
endmodule : tb_top
